/* File: core/indicator_blink_timer.sv */
// Message indicator sequencer: ramp, pulse, ramp, off, bursts and blanks
`timescale 1ns/1ps
module indicator_blink_timer #(
   parameter int MS_CYCLES = blink_pkg::MS_CYCLES_DEF
) (
   input wire logic CLK,            // 250 MHz clock
   input wire logic RESETN,         // Async reset, active low
   input wire logic WR_EN,          // Register write strobe
   input wire logic WR_SEL,         // 0 indicator timing, 1 blink timing
   input wire logic [7:0] WR_DATA,  // Write data
   input wire logic IND_EN,         // Indicator mode enable
   output logic [7:0] IND_REG,      // Indicator timing register readback
   output logic [7:0] BLINK_REG,    // Blink timing register readback
   output logic LED_ON,             // Indicator source active
   output logic RAMP_UP,            // Current ramping up
   output logic RAMP_DN,            // Current ramping down
   output logic [2:0] CURR_CODE,    // Current level code for the source
   output logic BLANKING            // Blank interval in progress
);
   import blink_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Decoders
   function automatic logic [11:0] ramp_ms(input logic [1:0] code);
      case (code)
         2'h0: ramp_ms = RAMP_MS_0;
         2'h1: ramp_ms = RAMP_MS_1;
         2'h2: ramp_ms = RAMP_MS_2;
         default: ramp_ms = RAMP_MS_3;
      endcase
   endfunction

   // Linear steps except two tabled codes
   function automatic logic [11:0] pulse_ms(input logic [3:0] code);
      if (code == PULSE_EXC_A) begin
         pulse_ms = PULSE_EXC_A_MS;
      end else if (code == PULSE_EXC_B) begin
         pulse_ms = PULSE_EXC_B_MS;
      end else begin
         pulse_ms = 12'(PULSE_STEP_MS * code);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] ind_r, ind_nxt, blink_r, blink_nxt;

   always_comb begin
      ind_nxt = ind_r;
      blink_nxt = blink_r;
      if (WR_EN && WR_SEL == SEL_IND) begin
         ind_nxt = WR_DATA;
      end else if (WR_EN && WR_SEL == SEL_BLINK) begin
         blink_nxt = WR_DATA;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ind_r <= IND_RST;
         blink_r <= BLINK_RST;
      end else begin
         ind_r <= ind_nxt;
         blink_r <= blink_nxt;
      end
   end

   assign IND_REG = ind_r;
   assign BLINK_REG = blink_r;

   ////////////////////////////////////////////////////////////////////////
   // Millisecond enable
   logic tick;

   ms_tick #(.MS_CYCLES(MS_CYCLES)) ms_tick_inst (
      .CLK(CLK),
      .RESETN(RESETN),
      .TICK(tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Sequencer. Ramp, pulse, period and blank settings are latched at burst start so a write mid-burst
   // cannot tear a period; the new values apply from the next burst.
   blink_state_t st_r, st_nxt;
   logic [11:0] ms_r, ms_nxt, ramp_r, ramp_nxt, pulse_r, pulse_nxt;
   logic [2:0] per_r, per_nxt, pidx_r, pidx_nxt;
   logic [3:0] blank_r, blank_nxt;
   logic [6:0] bidx_r, bidx_nxt;
   logic [11:0] len, period_len;
   logic [6:0] blank_tgt;
   logic done;
   logic led_nxt, rup_nxt, rdn_nxt, blk_nxt;
   logic led_r, rup_r, rdn_r, blk_r;

   assign period_len = 12'((ramp_r << 1) + (pulse_r << 1));
   // Operands widened first so a 15 x 7 product cannot wrap in 4 bits
   assign blank_tgt = 7'(blank_r) * 7'(per_r);

   // Length of the current phase in ms
   always_comb begin
      case (st_r)
         ST_RUP: len = ramp_r;
         ST_RDN: len = ramp_r;
         ST_PULSE: len = pulse_r;
         ST_OFF: len = pulse_r;
         ST_BLANK: len = period_len;
         default: len = 12'h0;
      endcase
   end

   // Zero-length phase ends at once; else on the tick that fills it
   assign done = (len == 12'h0) || (tick && (ms_r + 12'h1 == len));

   always_comb begin
      st_nxt = st_r;
      ms_nxt = ms_r;
      ramp_nxt = ramp_r;
      pulse_nxt = pulse_r;
      per_nxt = per_r;
      blank_nxt = blank_r;
      pidx_nxt = pidx_r;
      bidx_nxt = bidx_r;
      if (tick) begin
         ms_nxt = ms_r + 12'h1;
      end
      case (st_r)
         ST_IDLE: begin
            ms_nxt = 12'h0;
            ramp_nxt = ramp_ms(ind_r[RAMP_MSB:RAMP_LSB]);
            pulse_nxt = pulse_ms(blink_r[PULSE_MSB:PULSE_LSB]);
            per_nxt = ind_r[PERC_MSB:PERC_LSB];
            blank_nxt = blink_r[BLANK_MSB:BLANK_LSB];
            pidx_nxt = 3'h0;
            bidx_nxt = 7'h0;
            // Zero periods means zero active time: stay dark
            if (IND_EN && ind_r[PERC_MSB:PERC_LSB] != 3'h0) begin
               st_nxt = ST_RUP;
            end
         end
         ST_RUP: if (done) begin
            st_nxt = ST_PULSE;
            ms_nxt = 12'h0;
         end
         ST_PULSE: if (done) begin
            st_nxt = ST_RDN;
            ms_nxt = 12'h0;
         end
         ST_RDN: if (done) begin
            st_nxt = ST_OFF;
            ms_nxt = 12'h0;
         end
         ST_OFF: if (done) begin
            ms_nxt = 12'h0;
            if (pidx_r + 3'h1 != per_r) begin
               pidx_nxt = pidx_r + 3'h1;
               st_nxt = ST_RUP;
            end else if (blank_tgt != 7'h0) begin
               st_nxt = ST_BLANK;
            end else begin
               st_nxt = ST_IDLE;
            end
         end
         ST_BLANK: if (done) begin
            ms_nxt = 12'h0;
            if (bidx_r + 7'h1 == blank_tgt) begin
               st_nxt = ST_IDLE;
            end else begin
               bidx_nxt = bidx_r + 7'h1;
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
      // Dropping the enable ends the sequence at once
      if (!IND_EN) begin
         st_nxt = ST_IDLE;
      end
   end

   // Output decode from next state so outputs come from flops
   always_comb begin
      led_nxt = (st_nxt == ST_RUP) || (st_nxt == ST_PULSE) || (st_nxt == ST_RDN);
      rup_nxt = (st_nxt == ST_RUP);
      rdn_nxt = (st_nxt == ST_RDN);
      blk_nxt = (st_nxt == ST_BLANK);
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         st_r <= ST_IDLE;
         ms_r <= 12'h0;
         ramp_r <= RAMP_MS_0;
         pulse_r <= 12'h0;
         per_r <= 3'h0;
         blank_r <= 4'h0;
         pidx_r <= 3'h0;
         bidx_r <= 7'h0;
         led_r <= 1'b0;
         rup_r <= 1'b0;
         rdn_r <= 1'b0;
         blk_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         ms_r <= ms_nxt;
         ramp_r <= ramp_nxt;
         pulse_r <= pulse_nxt;
         per_r <= per_nxt;
         blank_r <= blank_nxt;
         pidx_r <= pidx_nxt;
         bidx_r <= bidx_nxt;
         led_r <= led_nxt;
         rup_r <= rup_nxt;
         rdn_r <= rdn_nxt;
         blk_r <= blk_nxt;
      end
   end

   assign LED_ON = led_r;
   assign RAMP_UP = rup_r;
   assign RAMP_DN = rdn_r;
   assign BLANKING = blk_r;
   assign CURR_CODE = ind_r[CURR_MSB:CURR_LSB];

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   // A phase counter past its length would stretch the period until the 12-bit counter wraps round
   property p_period_len;
      @(posedge CLK) disable iff (!RESETN)
      (st_r != ST_IDLE && len != 12'h0) |-> (ms_r < len);
   endproperty
   a_period_len: assert property (p_period_len) else $error("phase counter overran");

   property p_phase_order;
      @(posedge CLK) disable iff (!RESETN)
      (st_r == ST_RUP && IND_EN && done) |=> (st_r == ST_PULSE);
   endproperty
   a_phase_order: assert property (p_phase_order) else $error("ramp not followed by pulse");

   property p_burst_repeat;
      @(posedge CLK) disable iff (!RESETN)
      (st_r == ST_OFF && IND_EN && done && pidx_r + 3'h1 != per_r)
         |=> (st_r == ST_RUP && pidx_r == $past(pidx_r) + 3'h1);
   endproperty
   a_burst_repeat: assert property (p_burst_repeat) else $error("period not repeated");

   property p_blank_dark;
      @(posedge CLK) disable iff (!RESETN)
      (st_r == ST_BLANK) |=> !LED_ON;
   endproperty
   a_blank_dark: assert property (p_blank_dark) else $error("led on in blank");

   property p_blank_field;
      @(posedge CLK) disable iff (!RESETN)
      (WR_EN && WR_SEL == SEL_BLINK) |=> (BLINK_REG[7:4] == $past(WR_DATA[7:4]));
   endproperty
   a_blank_field: assert property (p_blank_field) else $error("blank field not stored");

   property p_pulse_exc;
      @(posedge CLK) disable iff (!RESETN)
      (st_r == ST_IDLE && blink_r[3:0] == 4'h3) |=> (pulse_r == 12'h05C);
   endproperty
   a_pulse_exc: assert property (p_pulse_exc) else $error("pulse code 3 not 92 ms");

   property p_ramp_top;
      @(posedge CLK) disable iff (!RESETN)
      (st_r == ST_IDLE && ind_r[7:6] == 2'h3) |=> (ramp_r == 12'h270);
   endproperty
   a_ramp_top: assert property (p_ramp_top) else $error("ramp code 3 not 624 ms");

   property p_zero_periods;
      @(posedge CLK) disable iff (!RESETN)
      (st_r == ST_IDLE && ind_r[5:3] == 3'h0) |=> (st_r == ST_IDLE);
   endproperty
   a_zero_periods: assert property (p_zero_periods) else $error("started with no periods");

   property p_restart;
      @(posedge CLK) disable iff (!RESETN)
      (st_r == ST_IDLE && IND_EN && ind_r[5:3] != 3'h0) |=> (LED_ON && RAMP_UP);
   endproperty
   a_restart: assert property (p_restart) else $error("burst did not restart");

   c_blank: cover property (@(posedge CLK) disable iff (!RESETN) st_r == ST_BLANK);
   c_repeat: cover property (@(posedge CLK) disable iff (!RESETN)
      st_r == ST_OFF ##1 st_r == ST_RUP);
   c_no_blank: cover property (@(posedge CLK) disable iff (!RESETN)
      st_r == ST_OFF ##1 st_r == ST_IDLE ##1 st_r == ST_RUP);
endmodule

/* File: core/blink_pkg.sv */
// Constants, encodings and timing for the indicator blink timer
package blink_pkg;
   // Base time unit and clock rate
   localparam int TICK_US = 1000;
   localparam int CLK_PERIOD_PS = 4000;
   // Tick span in ps over clock period in ps: 250000 clocks for 1 ms at 4 ns
   localparam int MS_CYCLES_DEF = (TICK_US * 1000 * 1000) / CLK_PERIOD_PS;
   // Register select codes for the write port
   localparam logic SEL_IND = 1'h0;
   localparam logic SEL_BLINK = 1'h1;
   // Reset values
   localparam logic [7:0] IND_RST = 8'h00;
   localparam logic [7:0] BLINK_RST = 8'h00;
   // Field positions, indicator timing register
   localparam int RAMP_MSB = 7;
   localparam int RAMP_LSB = 6;
   localparam int PERC_MSB = 5;
   localparam int PERC_LSB = 3;
   localparam int CURR_MSB = 2;
   localparam int CURR_LSB = 0;
   // Field positions, blink timing register
   localparam int BLANK_MSB = 7;
   localparam int BLANK_LSB = 4;
   localparam int PULSE_MSB = 3;
   localparam int PULSE_LSB = 0;
   // Ramp times in ms, per code
   localparam logic [11:0] RAMP_MS_0 = 12'h04E;
   localparam logic [11:0] RAMP_MS_1 = 12'h09C;
   localparam logic [11:0] RAMP_MS_2 = 12'h138;
   localparam logic [11:0] RAMP_MS_3 = 12'h270;
   // Pulse step and the two tabled exceptions, in ms
   localparam logic [11:0] PULSE_STEP_MS = 12'h020;
   localparam logic [3:0] PULSE_EXC_A = 4'h3;
   localparam logic [11:0] PULSE_EXC_A_MS = 12'h05C;
   localparam logic [3:0] PULSE_EXC_B = 4'h6;
   localparam logic [11:0] PULSE_EXC_B_MS = 12'h0C4;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_RUP   = 3'b001,
      ST_PULSE = 3'b010,
      ST_RDN   = 3'b011,
      ST_OFF   = 3'b100,
      ST_BLANK = 3'b101
   } blink_state_t;
endpackage

/* File: core/ms_tick.sv */
// Millisecond enable divider for the blink timer
`timescale 1ns/1ps
module ms_tick #(
   parameter int MS_CYCLES = blink_pkg::MS_CYCLES_DEF
) (
   input wire logic CLK,    // System clock
   input wire logic RESETN, // Async reset, active low
   output logic TICK        // One-cycle pulse each ms
);
   import blink_pkg::*;
   logic [31:0] cnt_r, cnt_nxt;
   logic tick_r, tick_nxt;

   // Wrap counter; tick registered so it is glitch free
   always_comb begin
      tick_nxt = 1'b0;
      if (cnt_r >= 32'(MS_CYCLES - 1)) begin
         cnt_nxt = 32'h0;
         tick_nxt = 1'b1;
      end else begin
         cnt_nxt = cnt_r + 32'h1;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         cnt_r <= 32'h0;
         tick_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign TICK = tick_r;
endmodule

/* File: testbench/indicator_blink_timer_tb.sv */
// Self-checking testbench for the indicator blink timer
`timescale 1ns/1ps
module indicator_blink_timer_tb;
   import blink_pkg::*;
   // Short ms tick keeps every phase a small, exact number of clocks
   localparam int MSC = 4;
   localparam int S_LED = 0;
   localparam int S_RUP = 1;
   localparam int S_RDN = 2;
   localparam int S_BLK = 3;
   logic CLK, RESETN, WR_EN, WR_SEL, IND_EN;
   logic [7:0] WR_DATA, IND_REG, BLINK_REG;
   logic LED_ON, RAMP_UP, RAMP_DN, BLANKING;
   logic [2:0] CURR_CODE;
   int n_fail = 0;
   int checks = 0;
   int n;
   int r;
   bit hit;

   indicator_blink_timer #(.MS_CYCLES(MSC)) indicator_blink_timer_inst (
      .CLK(CLK), .RESETN(RESETN), .WR_EN(WR_EN), .WR_SEL(WR_SEL), .WR_DATA(WR_DATA),
      .IND_EN(IND_EN), .IND_REG(IND_REG), .BLINK_REG(BLINK_REG), .LED_ON(LED_ON),
      .RAMP_UP(RAMP_UP), .RAMP_DN(RAMP_DN), .CURR_CODE(CURR_CODE), .BLANKING(BLANKING)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // 250 MHz clock
   initial begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Inputs change and outputs are sampled 1 ns after the edge, so no race
   task automatic step;
      @(posedge CLK);
      #1;
   endtask

   function automatic logic pick(input int k);
      case (k)
         S_LED: pick = LED_ON;
         S_RUP: pick = RAMP_UP;
         S_RDN: pick = RAMP_DN;
         default: pick = BLANKING;
      endcase
   endfunction

   // Pulse length in ms per code, with the two odd table entries
   function automatic int pw(input int c);
      if (c == 3) return 92;
      if (c == 6) return 196;
      return c * 32;
   endfunction

   // Bounded wait for an output to reach a level
   task automatic wait_for(input int k, input logic v, input int lim);
      hit = 0;
      for (int i = 0; i < lim && !hit; i++) begin
         if (pick(k) === v) hit = 1;
         else step;
      end
   endtask

   // Clocks an output stays at its present level
   task automatic span(input int k);
      logic v;
      v = pick(k);
      n = 0;
      while (pick(k) === v && n < 20000) begin
         step;
         n++;
      end
   endtask

   // Back-to-back writes, indicator then blink register
   task automatic write_pair(input logic [7:0] ind, input logic [7:0] blk);
      WR_EN = 1'b1;
      WR_SEL = SEL_IND;
      WR_DATA = ind;
      step;
      WR_SEL = SEL_BLINK;
      WR_DATA = blk;
      step;
      WR_EN = 1'b0;
      step;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Span check with a small tolerance for pipeline and tick alignment
   task automatic chk_t(input string nm, input int e, input int tol);
      checks++;
      if (n < e - tol || n > e + tol) begin
         n_fail++;
         $display("CHECK FAILED %s expected %0d seen %0d", nm, e, n);
      end
   endtask

   task automatic results;
      $display("Comparisons %0d, mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog sized well above the roughly 60k clocks the tests need
   initial begin
      repeat (80000) @(posedge CLK);
      n_fail++;
      $display("CHECK FAILED watchdog expected done seen hang");
      results;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      RESETN = 1'b0;
      WR_EN = 1'b0;
      WR_SEL = 1'b0;
      WR_DATA = 8'h00;
      IND_EN = 1'b0;
      repeat (2) @(posedge CLK);
      #1;
      RESETN = 1'b1;
      chk("ind_reg", 8'h00, IND_REG);
      chk("blink_reg", 8'h00, BLINK_REG);
      chk("led_on", 8'h00, {7'h00, LED_ON});
      write_pair(8'h5B, 8'hA5);
      chk("ind_reg", 8'h5B, IND_REG);
      chk("blink_reg", 8'hA5, BLINK_REG);
      chk("curr_code", 8'h03, {5'h00, CURR_CODE});
      // Period count zero must give no activity at all
      write_pair(8'h07, 8'h01);
      IND_EN = 1'b1;
      wait_for(S_LED, 1'b1, 400);
      chk("no_burst", 8'h00, {7'h00, hit});
      IND_EN = 1'b0;
      step;
      // Every pulse code, every ramp code, single period, no blank
      for (int i = 0; i < 16; i++) begin
         r = (i < 4) ? i : 0;
         write_pair({r[1:0], 3'h1, 3'h0}, {4'h0, i[3:0]});
         IND_EN = 1'b1;
         wait_for(S_RUP, 1'b1, 20);
         wait_for(S_RUP, 1'b0, 3000);
         span(S_RDN);
         chk_t("pulse", (i == 0) ? 1 : pw(i) * MSC, 2);
         span(S_RDN);
         chk_t("ramp_dn", (78 << r) * MSC, 2);
         span(S_LED);
         chk_t("off_restart", pw(i) * MSC + 1, 3);
         chk("no_blank", 8'h00, {7'h00, BLANKING});
         IND_EN = 1'b0;
         repeat (3) step;
         chk("abort", 8'h00, {6'h00, LED_ON, RAMP_UP});
      end
      // Two periods, 78 ms ramp, 92 ms pulse, blank count 1
      write_pair(8'h13, 8'h13);
      IND_EN = 1'b1;
      wait_for(S_LED, 1'b1, 20);
      wait_for(S_LED, 1'b0, 4000);
      span(S_LED);
      chk_t("off", 368, 2);
      span(S_RUP);
      chk_t("ramp_up", 312, 2);
      span(S_RDN);
      chk_t("pulse", 368, 2);
      span(S_RDN);
      chk_t("ramp_dn", 312, 2);
      span(S_BLK);
      chk_t("off_to_blank", 368, 2);
      span(S_BLK);
      chk_t("blank", 2720, 2);
      wait_for(S_LED, 1'b1, 10);
      chk("restart", 8'h01, {7'h00, hit});
      // Abort in mid-blank
      wait_for(S_BLK, 1'b1, 4000);
      repeat (100) step;
      IND_EN = 1'b0;
      repeat (3) step;
      chk("blank_abort", 8'h00, {6'h00, BLANKING, LED_ON});
      results;
   end
endmodule
